//--- design/pps_sequencer.sv
// pinboard program sequencer with axi4-lite control
`timescale 1ns/1ns
module pps_sequencer
  import pps_pkg::*;
#(
  parameter int NUM_BOARDS = 8
) (
  input  wire logic                  I_MCLK,
  input  wire logic                  I_RST,
  input  wire logic                  I_CE,
  input  wire logic [AXI_ADDR_W-1:0] I_AWADDR,
  input  wire logic                  I_AWVALID,
  output logic                       O_AWREADY,
  input  wire logic [31:0]           I_WDATA,
  input  wire logic [3:0]            I_WSTRB,
  input  wire logic                  I_WVALID,
  output logic                       O_WREADY,
  output logic [1:0]                 O_BRESP,
  output logic                       O_BVALID,
  input  wire logic                  I_BREADY,
  input  wire logic [AXI_ADDR_W-1:0] I_ARADDR,
  input  wire logic                  I_ARVALID,
  output logic                       O_ARREADY,
  output logic [31:0]                O_RDATA,
  output logic [1:0]                 O_RRESP,
  output logic                       O_RVALID,
  input  wire logic                  I_RREADY,
  output logic                       O_FETCH_REQ,
  output logic [3:0]                 O_FETCH_BOARD,
  output logic [3:0]                 O_FETCH_STEP,
  input  wire logic                  I_INSTR_VALID,
  input  wire logic [3:0]            I_INSTR_OP,
  input  wire logic [3:0]            I_INSTR_F2,
  input  wire logic [3:0]            I_INSTR_F3,
  input  wire logic                  I_ACC_NEG,
  input  wire logic [3:0]            I_KEY_X,
  input  wire logic [3:0]            I_KEY_Y,
  output logic                       O_EXEC_VALID,
  output logic [3:0]                 O_EXEC_OP,
  output logic [3:0]                 O_EXEC_F2,
  output logic [3:0]                 O_EXEC_F3,
  output logic                       O_SHIFT_LEFT,
  output logic [3:0]                 O_SHIFT_COUNT,
  output logic [3:0]                 O_PRINT_BAR,
  output logic                       O_PRINT_SUPPRESS,
  output logic [3:0]                 O_SWITCH_FIRST,
  output logic [3:0]                 O_SWITCH_SECOND,
  output logic [3:0]                 O_BOARD_SEL
);

  localparam int BRD_W = $clog2(NUM_BOARDS);

  if (NUM_BOARDS < 2 || NUM_BOARDS > 8) begin : g_bad_boards
    $error("pps_sequencer: NUM_BOARDS must be 2 to 8");
  end

  pps_state_t       state;
  logic [BRD_W-1:0] cur_board;
  logic [3:0]       cur_step;
  logic [3:0]       op_q;
  logic [3:0]       f2_q;
  logic [3:0]       f3_q;
  logic [3:0]       sw_first;
  logic [3:0]       sw_second;
  logic [BRD_W-1:0] tgt_board;
  logic [3:0]       tgt_step;
  logic             tgt_resume;
  logic [3:0]       xfer_cnt;
  logic [3:0]       ptr_rdata;
  logic             ctrl_run;

  // axi slave state
  logic                  aw_held;
  logic                  w_held;
  logic [AXI_ADDR_W-1:0] aw_addr;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  logic                  wr_fire;
  logic                  start_load;

  // decode of the held instruction
  logic [3:0]       f2_res;
  logic [3:0]       f3_res;
  logic [3:0]       brd_num;
  logic [BRD_W-1:0] next_tgt_board;
  logic             take_xfer;
  logic             bump_skip;
  logic [3:0]       bump_val;
  logic [3:0]       load_val;
  logic [3:0]       next_step;
  logic             exec_now;

  assign exec_now = (state == ST_EXEC);

  // fields resolved against operator keys
  assign f2_res = pps_resolve(f2_q, I_KEY_X, I_KEY_Y);
  assign f3_res = pps_resolve(f3_q, I_KEY_X, I_KEY_Y);

  always_comb begin
    brd_num = f2_res;
    if (f2_q == FLD_SW_FIRST) begin
      brd_num = sw_first;
    end
    if (brd_num == 4'h0 || brd_num > 4'(NUM_BOARDS)) begin
      next_tgt_board = cur_board;
    end else begin
      next_tgt_board = BRD_W'(brd_num - 4'h1);
    end
  end

  // transfer only for branch, or sign jump on strictly negative
  assign take_xfer = (op_q == OP_BRANCH) || ((op_q == OP_SIGN_JUMP) && I_ACC_NEG);

  always_comb begin
    bump_val  = (f2_res[0] ? sw_second : sw_first) + 4'h1;
    bump_skip = 1'b0;
    if (op_q == OP_BUMP && bump_val == f3_res) begin
      bump_val  = RST_SWITCH;
      bump_skip = 1'b1;
    end
  end

  always_comb begin
    load_val = f3_res;
    if (f3_q == FLD_SW_FIRST) begin
      load_val = sw_first;
    end else if (f3_q == FLD_SW_SECOND) begin
      load_val = sw_second;
    end
  end

  // four-bit add wraps 15 to 0 inside the board
  assign next_step = cur_step + (bump_skip ? 4'h2 : 4'h1);

  // sequencing state machine
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      state <= ST_IDLE;
    end else if (I_CE) begin
      unique case (state)
        ST_IDLE: begin
          if (ctrl_run) begin
            state <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (!ctrl_run) begin
            state <= ST_IDLE;
          end else if (I_INSTR_VALID) begin
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          state <= take_xfer ? ST_XFER : ST_FETCH;
        end
        ST_XFER: begin
          if (tgt_board == cur_board && xfer_cnt == SAME_BOARD_XFER_CYC - 4'h1) begin
            state <= ST_FETCH;
          end
        end
      endcase
    end
  end

  // instruction capture, op, second and third field together in one cycle
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      op_q <= OP_OTHER;
      f2_q <= 4'h0;
      f3_q <= 4'h0;
    end else if (I_CE && state == ST_FETCH && I_INSTR_VALID) begin
      op_q <= I_INSTR_OP;
      f2_q <= I_INSTR_F2;
      f3_q <= I_INSTR_F3;
    end
  end

  // transfer target capture
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      tgt_board  <= '0;
      tgt_step   <= RST_STEP;
      tgt_resume <= 1'b0;
    end else if (I_CE && exec_now && take_xfer) begin
      tgt_board  <= next_tgt_board;
      tgt_step   <= f3_res;
      tgt_resume <= (op_q == OP_BRANCH) && (f3_q == FLD_RESUME);
    end
  end

  // board selector and step position
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      cur_board <= '0;
      cur_step  <= RST_STEP;
      xfer_cnt  <= 4'h0;
    end else if (I_CE) begin
      if (state == ST_IDLE && start_load) begin
        cur_board <= BRD_W'(w_data[START_BRD_LO +: 4]);
        cur_step  <= w_data[START_STEP_LO +: 4];
      end else if (exec_now) begin
        cur_step <= next_step;
        xfer_cnt <= 4'h0;
      end else if (state == ST_XFER) begin
        if (tgt_board != cur_board) begin
          if (xfer_cnt == BOARD_STEP_CYC - 4'h1) begin
            xfer_cnt  <= 4'h0;
            cur_board <= (cur_board == BRD_W'(NUM_BOARDS - 1)) ? '0 : cur_board + BRD_W'(1);
          end else begin
            xfer_cnt <= xfer_cnt + 4'h1;
          end
        end else if (xfer_cnt == SAME_BOARD_XFER_CYC - 4'h1) begin
          cur_step <= tgt_resume ? ptr_rdata : tgt_step;
        end else begin
          xfer_cnt <= xfer_cnt + 4'h1;
        end
      end
    end
  end

  // loop switches
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      sw_first  <= RST_SWITCH;
      sw_second <= RST_SWITCH;
    end else if (I_CE && exec_now) begin
      if (op_q == OP_BUMP) begin
        if (f2_res[0]) begin
          sw_second <= bump_val;
        end else begin
          sw_first <= bump_val;
        end
      end else if (op_q == OP_LOAD) begin
        if (f2_res[0]) begin
          sw_second <= load_val;
        end else begin
          sw_first <= load_val;
        end
      end
    end
  end

  // own-board pointer advanced by every executed instruction
  pps_step_mem #(
    .DEPTH (NUM_BOARDS),
    .WIDTH (STEP_W)
  ) u_ptr (
    .i_clk   (I_MCLK),
    .i_rst   (I_RST),
    .i_ce    (I_CE),
    .i_we    (exec_now),
    .i_waddr (cur_board),
    .i_wdata (next_step),
    .i_raddr (tgt_board),
    .o_rdata (ptr_rdata)
  );

  // execution outputs toward arithmetic and printer
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      O_EXEC_VALID     <= 1'b0;
      O_EXEC_OP        <= OP_OTHER;
      O_EXEC_F2        <= 4'h0;
      O_EXEC_F3        <= 4'h0;
      O_SHIFT_LEFT     <= 1'b0;
      O_SHIFT_COUNT    <= 4'h0;
      O_PRINT_BAR      <= 4'h0;
      O_PRINT_SUPPRESS <= 1'b0;
    end else if (I_CE) begin
      O_EXEC_VALID <= exec_now;
      if (exec_now) begin
        O_EXEC_OP <= op_q;
        O_EXEC_F2 <= f2_res;
        O_EXEC_F3 <= f3_res;
        if (op_q == OP_SHIFT) begin
          O_SHIFT_LEFT  <= (f2_res == DIR_LEFT);
          O_SHIFT_COUNT <= f3_res;
        end
        if (op_q == OP_PRINT) begin
          O_PRINT_BAR      <= f2_res;
          O_PRINT_SUPPRESS <= (f3_q == FLD_KEY_Y) && (I_KEY_Y == 4'h0);
        end
      end
    end
  end

  assign O_FETCH_REQ     = (state == ST_FETCH);
  assign O_FETCH_BOARD   = 4'(cur_board) + 4'h1;
  assign O_FETCH_STEP    = cur_step;
  assign O_BOARD_SEL     = 4'(cur_board) + 4'h1;
  assign O_SWITCH_FIRST  = sw_first;
  assign O_SWITCH_SECOND = sw_second;

  // axi4-lite write path
  assign O_AWREADY  = !aw_held && !O_BVALID;
  assign O_WREADY   = !w_held && !O_BVALID;
  assign wr_fire    = aw_held && w_held && !O_BVALID;
  assign start_load = wr_fire && aw_addr == REG_START && w_strb[0];

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      aw_addr  <= '0;
      w_data   <= 32'h0000_0000;
      w_strb   <= 4'h0;
      O_BVALID <= 1'b0;
      O_BRESP  <= RESP_OKAY;
      ctrl_run <= 1'b0;
    end else if (I_CE) begin
      if (I_AWVALID && O_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY) begin
        w_held <= 1'b1;
        w_data <= I_WDATA;
        w_strb <= I_WSTRB;
      end
      if (wr_fire) begin
        aw_held  <= 1'b0;
        w_held   <= 1'b0;
        O_BVALID <= 1'b1;
        O_BRESP  <= (aw_addr == REG_CTRL || aw_addr == REG_START) ? RESP_OKAY : RESP_SLVERR;
        if (aw_addr == REG_CTRL && w_strb[0]) begin
          ctrl_run <= w_data[CTRL_RUN_BIT];
        end
      end else if (O_BVALID && I_BREADY) begin
        O_BVALID <= 1'b0;
      end
    end
  end

  // axi4-lite read path
  assign O_ARREADY = !O_RVALID;

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      O_RVALID <= 1'b0;
      O_RDATA  <= 32'h0000_0000;
      O_RRESP  <= RESP_OKAY;
    end else if (I_CE) begin
      if (I_ARVALID && O_ARREADY) begin
        O_RVALID <= 1'b1;
        O_RRESP  <= RESP_OKAY;
        O_RDATA  <= 32'h0000_0000;
        unique case (I_ARADDR)
          REG_CTRL: begin
            O_RDATA[CTRL_RUN_BIT] <= ctrl_run;
          end
          REG_START: begin
            O_RDATA[START_STEP_LO +: 4] <= cur_step;
            O_RDATA[START_BRD_LO +: 4]  <= 4'(cur_board);
          end
          REG_STATUS: begin
            O_RDATA[STAT_STEP_LO +: 4] <= cur_step;
            O_RDATA[STAT_BRD_LO +: 4]  <= 4'(cur_board);
            O_RDATA[STAT_SWF_LO +: 4]  <= sw_first;
            O_RDATA[STAT_SWS_LO +: 4]  <= sw_second;
            O_RDATA[STAT_BUSY_BIT]     <= (state != ST_IDLE);
          end
          default: begin
            O_RRESP <= RESP_SLVERR;
          end
        endcase
      end else if (O_RVALID && I_RREADY) begin
        O_RVALID <= 1'b0;
      end
    end
  end

  a_step_wrap: assert property (@(posedge I_MCLK) disable iff (I_RST || !I_CE)
    exec_now && !take_xfer && !bump_skip && cur_step == 4'hF |=> cur_step == 4'h0)
    else $error("step did not wrap to zero");

  a_switch_wrap: assert property (@(posedge I_MCLK) disable iff (I_RST || !I_CE)
    exec_now && op_q == OP_BUMP && !f2_res[0] && sw_first == 4'hF && f3_res != 4'h0 |=> sw_first == 4'h0)
    else $error("first switch did not wrap");

  a_zero_positive: assert property (@(posedge I_MCLK) disable iff (I_RST || !I_CE)
    exec_now && op_q == OP_SIGN_JUMP && !I_ACC_NEG |=> state == ST_FETCH && cur_step == $past(cur_step) + 4'h1)
    else $error("sign jump taken on non-negative");

  a_seek_forward: assert property (@(posedge I_MCLK) disable iff (I_RST || !I_CE)
    state == ST_XFER && tgt_board != cur_board && xfer_cnt == BOARD_STEP_CYC - 4'h1
    |=> cur_board == (($past(cur_board) == BRD_W'(NUM_BOARDS - 1)) ? '0 : $past(cur_board) + BRD_W'(1)))
    else $error("selector did not step forward");

  a_same_cost: assert property (@(posedge I_MCLK) disable iff (I_RST || !I_CE)
    exec_now && take_xfer && next_tgt_board == cur_board |=> state == ST_XFER ##1 state == ST_XFER ##1 state == ST_FETCH)
    else $error("same-board transfer cost wrong");

  a_shift_keyed: assert property (@(posedge I_MCLK) disable iff (I_RST || !I_CE)
    exec_now && op_q == OP_SHIFT && f2_q == FLD_KEY_X |=> O_SHIFT_LEFT == ($past(I_KEY_X) == DIR_LEFT))
    else $error("keyed shift direction wrong");

  a_print_mute: assert property (@(posedge I_MCLK) disable iff (I_RST || !I_CE)
    exec_now && op_q == OP_PRINT && f3_q == FLD_KEY_Y && I_KEY_Y == 4'h0 |=> O_PRINT_SUPPRESS && O_EXEC_VALID)
    else $error("print not suppressed");

  a_copy_switch: assert property (@(posedge I_MCLK) disable iff (I_RST || !I_CE)
    exec_now && op_q == OP_LOAD && f2_q == 4'h1 && f3_q == FLD_SW_FIRST |=> sw_second == $past(sw_first))
    else $error("switch copy failed");

  a_resume_ptr: assert property (@(posedge I_MCLK) disable iff (I_RST || !I_CE)
    state == ST_XFER && tgt_resume && tgt_board == cur_board && xfer_cnt == SAME_BOARD_XFER_CYC - 4'h1
    |=> state == ST_FETCH && cur_step == $past(ptr_rdata))
    else $error("resume step not taken from pointer");

endmodule : pps_sequencer

//--- design/pps_step_mem.sv
// per-board step pointer store with registered read
`timescale 1ns/1ns
module pps_step_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 4
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  input  wire logic                     i_ce,
  input  wire logic                     i_we,
  input  wire logic [$clog2(DEPTH)-1:0] i_waddr,
  input  wire logic [WIDTH-1:0]         i_wdata,
  input  wire logic [$clog2(DEPTH)-1:0] i_raddr,
  output logic      [WIDTH-1:0]         o_rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH < 2 || WIDTH < 1) begin : g_bad_geometry
    $error("pps_step_mem: bad geometry");
  end

  // pointer storage
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (i_ce && i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // registered read
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else if (i_ce) begin
      o_rdata <= mem[i_raddr];
    end
  end

endmodule : pps_step_mem

//--- shared/pps_pkg.sv
// shared constants, codes and helpers for the pinboard program sequencer
package pps_pkg;

  // field and instruction layout
  localparam int FIELD_W = 4;
  localparam int STEP_W  = 4;

  // special field codes; plain digits are 0 to 9
  localparam logic [3:0] FLD_KEY_X     = 4'hA;
  localparam logic [3:0] FLD_KEY_Y     = 4'hB;
  localparam logic [3:0] FLD_SW_FIRST  = 4'hC;
  localparam logic [3:0] FLD_SW_SECOND = 4'hD;
  localparam logic [3:0] FLD_RESUME    = 4'hE;

  // operation codes
  localparam logic [3:0] OP_OTHER     = 4'h0;
  localparam logic [3:0] OP_BRANCH    = 4'h1;
  localparam logic [3:0] OP_SIGN_JUMP = 4'h2;
  localparam logic [3:0] OP_SHIFT     = 4'h3;
  localparam logic [3:0] OP_PRINT     = 4'h4;
  localparam logic [3:0] OP_BUMP      = 4'h5;
  localparam logic [3:0] OP_LOAD      = 4'h6;

  // shift direction codes
  localparam logic [3:0] DIR_LEFT  = 4'h1;
  localparam logic [3:0] DIR_RIGHT = 4'h2;

  // transfer costs in clock cycles
  localparam logic [3:0] SAME_BOARD_XFER_CYC = 4'h2;
  localparam logic [3:0] BOARD_STEP_CYC      = 4'h3;

  // register map, byte addresses
  localparam int          AXI_ADDR_W = 12;
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_START  = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;

  // register fields
  localparam int CTRL_RUN_BIT  = 0;
  localparam int START_STEP_LO = 0;
  localparam int START_BRD_LO  = 4;
  localparam int STAT_STEP_LO  = 0;
  localparam int STAT_BRD_LO   = 4;
  localparam int STAT_SWF_LO   = 8;
  localparam int STAT_SWS_LO   = 12;
  localparam int STAT_BUSY_BIT = 16;

  // reset values
  localparam logic [3:0] RST_STEP   = 4'h0;
  localparam logic [3:0] RST_SWITCH = 4'h0;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_EXEC  = 2'b10,
    ST_XFER  = 2'b11
  } pps_state_t;

  // replace keyed digit codes by the operator key values
  function automatic logic [3:0] pps_resolve(input logic [3:0] fld, input logic [3:0] kx, input logic [3:0] ky);
    if (fld == FLD_KEY_X) begin
      return kx;
    end else if (fld == FLD_KEY_Y) begin
      return ky;
    end
    return fld;
  endfunction : pps_resolve

endpackage : pps_pkg

//--- verification/pps_prog_model.sv
// program store model answering fetch requests of the sequencer
`timescale 1ns/1ns
module pps_prog_model (
  input  wire logic       i_clk,
  input  wire logic       i_req,
  input  wire logic [3:0] i_board,
  input  wire logic [3:0] i_step,
  output logic            o_valid,
  output logic [3:0]      o_op,
  output logic [3:0]      o_f2,
  output logic [3:0]      o_f3
);
  logic [11:0] mem [0:127];
  logic        armed = 1'b0;
  int          lag = 0;
  int          cnt = 0;
  initial begin
    o_valid = 1'b0;
    {o_op, o_f2, o_f3} = 12'h000;
  end
  always @(posedge i_clk) begin
    if (o_valid && i_req) begin
      o_valid <= 1'b0;
      armed <= 1'b0;
      {o_op, o_f2, o_f3} <= ~{o_op, o_f2, o_f3};
    end else if (i_req && armed && !o_valid && cnt >= lag) begin
      o_valid <= 1'b1;
      cnt <= 0;
      {o_op, o_f2, o_f3} <= mem[{i_board[2:0] - 3'h1, i_step}];
    end else if (!o_valid) begin
      cnt <= cnt + 1;
      {o_op, o_f2, o_f3} <= ~{o_op, o_f2, o_f3};
    end
  end
endmodule : pps_prog_model

//--- verification/tb_pinboard_program_sequencer.sv
// self-checking bench for the pinboard program sequencer
`timescale 1ns/1ns
module tb_pinboard_program_sequencer
  import pps_pkg::*;
;
  logic I_MCLK, I_RST, I_CE, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY, I_INSTR_VALID, I_ACC_NEG;
  logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_FETCH_REQ, O_EXEC_VALID, O_SHIFT_LEFT, O_PRINT_SUPPRESS;
  logic [11:0] I_AWADDR, I_ARADDR;
  logic [31:0] I_WDATA, O_RDATA, d;
  logic [1:0]  O_BRESP, O_RRESP, r;
  logic [3:0]  I_WSTRB, I_INSTR_OP, I_INSTR_F2, I_INSTR_F3, I_KEY_X, I_KEY_Y, last;
  logic [3:0]  O_FETCH_BOARD, O_FETCH_STEP, O_EXEC_OP, O_EXEC_F2, O_EXEC_F3, O_SHIFT_COUNT, O_PRINT_BAR;
  logic [3:0]  O_SWITCH_FIRST, O_SWITCH_SECOND, O_BOARD_SEL;
  int          miscompares = 0, checks_done = 0, brd = 4, stp = 15, swf = 0, sws = 0, dur, ds, dn, dp;
  int          ptr [1:8] = '{default: 0};
  logic [3:0]  sq [$];

  pps_sequencer #(.NUM_BOARDS(8)) dut (.I_MCLK, .I_RST, .I_CE, .I_AWADDR, .I_AWVALID, .O_AWREADY, .I_WDATA,
    .I_WSTRB, .I_WVALID, .O_WREADY, .O_BRESP, .O_BVALID, .I_BREADY, .I_ARADDR, .I_ARVALID, .O_ARREADY,
    .O_RDATA, .O_RRESP, .O_RVALID, .I_RREADY, .O_FETCH_REQ, .O_FETCH_BOARD, .O_FETCH_STEP, .I_INSTR_VALID,
    .I_INSTR_OP, .I_INSTR_F2, .I_INSTR_F3, .I_ACC_NEG, .I_KEY_X, .I_KEY_Y, .O_EXEC_VALID, .O_EXEC_OP,
    .O_EXEC_F2, .O_EXEC_F3, .O_SHIFT_LEFT, .O_SHIFT_COUNT, .O_PRINT_BAR, .O_PRINT_SUPPRESS,
    .O_SWITCH_FIRST, .O_SWITCH_SECOND, .O_BOARD_SEL);
  pps_prog_model prog (.i_clk(I_MCLK), .i_req(O_FETCH_REQ), .i_board(O_FETCH_BOARD), .i_step(O_FETCH_STEP),
    .o_valid(I_INSTR_VALID), .o_op(I_INSTR_OP), .o_f2(I_INSTR_F2), .o_f3(I_INSTR_F3));

  initial begin
    I_MCLK = 1'b0;
    forever #2 I_MCLK = ~I_MCLK;
  end
  always @(negedge I_MCLK) if (O_BOARD_SEL !== last) begin
    sq.push_back(O_BOARD_SEL);
    last = O_BOARD_SEL;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, s);
    end
  endtask : chk

  task automatic axw(input logic [11:0] a, input logic [31:0] v, output logic [1:0] q);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge I_MCLK);
    I_AWADDR <= a; I_WDATA <= v; I_AWVALID <= 1'b1; I_WVALID <= 1'b1; I_BREADY <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge I_MCLK);
      ta = ta | (I_AWVALID & O_AWREADY);
      tw = tw | (I_WVALID & O_WREADY);
      @(posedge I_MCLK);
      if (ta) I_AWVALID <= 1'b0;
      if (tw) I_WVALID <= 1'b0;
    end
    do @(negedge I_MCLK); while (O_BVALID !== 1'b1);
    q = O_BRESP;
    @(posedge I_MCLK);
    I_BREADY <= 1'b0;
  endtask : axw

  task automatic axr(input logic [11:0] a, output logic [31:0] v, output logic [1:0] q);
    @(posedge I_MCLK);
    I_ARADDR <= a; I_ARVALID <= 1'b1; I_RREADY <= 1'b1;
    do @(negedge I_MCLK); while (O_ARREADY !== 1'b1);
    @(posedge I_MCLK);
    I_ARVALID <= 1'b0;
    do @(negedge I_MCLK); while (O_RVALID !== 1'b1);
    v = O_RDATA;
    q = O_RRESP;
    @(posedge I_MCLK);
    I_RREADY <= 1'b0;
  endtask : axr

  function automatic logic [3:0] rs(input logic [3:0] f, kx, ky);
    return f == FLD_KEY_X ? kx : f == FLD_KEY_Y ? ky : f;
  endfunction : rs

  task automatic step(input logic [3:0] op, f2, f3, kx = 0, ky = 0, input logic ng = 0);
    int b, s, inc, v;
    logic [3:0] r2, r3;
    @(posedge I_MCLK);
    I_KEY_X <= kx; I_KEY_Y <= ky; I_ACC_NEG <= ng;
    @(negedge I_MCLK);
    prog.mem[{brd[2:0] - 3'h1, stp[3:0]}] = {op, f2, f3};
    prog.lag = $urandom_range(0, 3);
    prog.armed = 1'b1;
    sq.delete();
    last = brd[3:0];
    r2 = rs(f2, kx, ky);
    r3 = rs(f3, kx, ky);
    do @(negedge I_MCLK); while (O_EXEC_VALID !== 1'b1);
    chk("op", op, O_EXEC_OP);
    chk("f2", r2, O_EXEC_F2);
    chk("f3", r3, O_EXEC_F3);
    if (op == OP_SHIFT) chk("left", r2 == DIR_LEFT, O_SHIFT_LEFT);
    if (op == OP_SHIFT) chk("count", r3, O_SHIFT_COUNT);
    if (op == OP_PRINT) chk("bar", r2, O_PRINT_BAR);
    if (op == OP_PRINT) chk("suppress", f3 == FLD_KEY_Y && ky == 0, O_PRINT_SUPPRESS);
    inc = 1;
    b = brd;
    if (op == OP_BUMP) begin
      v = ((r2[0] ? sws : swf) + 1) % 16;
      if (v == r3) begin
        v = 0;
        inc = 2;
      end
      if (r2[0]) sws = v; else swf = v;
    end
    if (op == OP_LOAD) begin
      v = f3 == FLD_SW_FIRST ? swf : f3 == FLD_SW_SECOND ? sws : r3;
      if (r2[0]) sws = v; else swf = v;
    end
    ptr[brd] = (stp + inc) % 16;
    s = ptr[brd];
    if (op == OP_BRANCH || (op == OP_SIGN_JUMP && ng)) begin
      b = f2 == FLD_SW_FIRST ? swf : r2;
      if (b < 1 || b > 8) b = brd;
      s = f3 == FLD_RESUME ? ptr[b] : r3;
    end
    dur = 0;
    while (O_FETCH_REQ !== 1'b1) begin
      @(negedge I_MCLK);
      dur++;
    end
    chk("board", b, O_FETCH_BOARD);
    chk("step", s, O_FETCH_STEP);
    chk("first", swf, O_SWITCH_FIRST);
    chk("second", sws, O_SWITCH_SECOND);
    v = brd;
    while (v != b) begin
      v = v % 8 + 1;
      chk("sel", v, sq.size() > 0 ? sq.pop_front() : 4'h0);
    end
    chk("sel_extra", 0, sq.size());
    brd = b;
    stp = s;
  endtask : step

  initial begin
    #200000;
    miscompares++;
    results;
  end

  initial begin
    {I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY, I_ACC_NEG} = 6'h00;
    {I_AWADDR, I_ARADDR, I_WDATA, I_KEY_X, I_KEY_Y} = 64'h0;
    I_CE = 1'b1;
    I_WSTRB = 4'hF;
    I_RST = 1'b1;
    void'($urandom(32'hC9D8EECD));
    repeat (16) @(posedge I_MCLK);
    I_RST <= 1'b0;
    axr(REG_STATUS, d, r);
    chk("status_rst", 32'h0, d);
    axr(12'h00C, d, r);
    chk("rresp", RESP_SLVERR, r);
    axw(REG_STATUS, 32'h1, r);
    chk("bresp", RESP_SLVERR, r);
    axw(REG_START, 32'h3F, r);
    chk("start", RESP_OKAY, r);
    axr(REG_START, d, r);
    chk("start_rd", 32'h3F, d);
    axw(REG_CTRL, 32'h1, r);
    step(OP_OTHER, 4'h0, 4'h0);
    step(OP_LOAD, 4'h0, 4'hF);
    step(OP_BUMP, 4'h0, 4'h9);
    step(OP_LOAD, 4'h1, 4'h5);
    step(OP_LOAD, 4'h0, FLD_SW_SECOND);
    step(OP_LOAD, 4'h1, 4'h0);
    step(OP_LOAD, 4'h1, FLD_SW_FIRST);
    step(OP_SIGN_JUMP, 4'h0, 4'h2);
    step(OP_SIGN_JUMP, 4'h0, 4'h9, 4'h0, 4'h0, 1'b1);
    ds = dur;
    step(OP_BRANCH, 4'h5, 4'h0);
    dn = dur;
    step(OP_BRANCH, 4'h4, FLD_RESUME);
    dp = dur;
    chk("cost_order", 1, ds < dn && dn < dp);
    chk("cost_span", dn + 6 * BOARD_STEP_CYC, dp);
    step(OP_LOAD, 4'h0, 4'h5);
    step(OP_BRANCH, FLD_SW_FIRST, FLD_RESUME);
    repeat (4) step(OP_BRANCH, FLD_KEY_X, FLD_KEY_Y, 4'($urandom_range(1, 8)), 4'($urandom_range(0, 9)));
    for (int k = 1; k <= 2; k++) step(OP_SHIFT, FLD_KEY_X, FLD_KEY_Y, 4'(k), 4'($urandom_range(0, 15)));
    step(OP_PRINT, FLD_KEY_X, FLD_KEY_Y, 4'($urandom_range(0, 9)), 4'h0);
    step(OP_PRINT, FLD_KEY_X, FLD_KEY_Y, 4'h2, 4'h3);
    step(OP_LOAD, FLD_KEY_X, 4'h0, 4'h1);
    repeat (2) step(OP_BUMP, FLD_KEY_X, FLD_KEY_Y, 4'h1, 4'h2);
    axr(REG_STATUS, d, r);
    chk("status", 32'h10000 | (sws << 12) | (swf << 8) | ((brd - 1) << 4) | stp, d);
    results;
  end
endmodule : tb_pinboard_program_sequencer
